// *** logic/eff_host_framer.v ***
// e1 time slot 0 / time slot 16 overhead formatter and checker
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "eff_map.vh"
module eff_host_framer (
    core_clk,       // 20 MHz system clock
    reset_n,        // synchronous reset, active low
    clk_en,         // freezes all state while low
    paddr,          // apb address
    psel,           // apb select
    penable,        // apb enable
    pwrite,         // apb direction
    pwdata,         // apb write data
    prdata,         // apb read data
    pready,         // apb ready
    pslverr,        // apb error, unmapped address
    irq,            // level interrupt
    line_tx_tick,   // one pulse per transmit bit
    line_tx_data,   // transmit line bit
    tx_payload,     // payload bit for non-overhead slots
    tx_payload_req, // payload bit taken this cycle
    line_rx_tick,   // one pulse per received bit
    line_rx_data,   // receive line pin
    line_rx_sync,   // receive pin, marks bit1 of frame 0
    rx_payload,     // received payload bit
    rx_payload_vld  // payload bit valid pulse
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire        clk_en;
    input  wire [7:0]  paddr;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata;
    output wire        pready;
    output reg         pslverr;
    output wire        irq;
    input  wire        line_tx_tick;
    output reg         line_tx_data;
    input  wire        tx_payload;
    output wire        tx_payload_req;
    input  wire        line_rx_tick;
    input  wire        line_rx_data;
    input  wire        line_rx_sync;
    output reg         rx_payload;
    output reg         rx_payload_vld;

    // serial crc-4 step, bits fed first to last
    function [3:0] crc_step;
        input [3:0] crc;
        input       d;
        begin
            crc_step = {crc[2:0], 1'b0} ^ ((d ^ crc[3]) ? `EFF_CRC_POLY : 4'h0);
        end
    endfunction

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    reg [`EFF_CTRL_W-1:0] ctrl_r;
    reg [`EFF_ST_W-1:0]   status_r;
    reg [`EFF_ST_W-1:0]   mask_r;
    reg [31:0]            txctl_r;
    reg [31:0]            rxctl_r;
    reg [7:0]             txdl_r;
    reg [7:0]             rxdl_r;
    reg [4:0]             rxsig_sel_r;
    reg [`EFF_ST_W-1:0]   ev;
    reg                   rx_alarm_r, rx_yel_r;
    reg [1:0]             rx_e_r;
    reg [4:0]             rx_sa_r;
    reg [2:0]             rx_x_r;

    wire en     = ctrl_r[`EFF_CTRL_EN];
    wire irsm   = ctrl_r[`EFF_CTRL_IRSM];
    wire crc_on = ctrl_r[`EFF_CTRL_CRC];
    wire si_bit = ctrl_r[`EFF_CTRL_SI];
    wire [4:0] sa_bits = ctrl_r[`EFF_CTRL_SA_HI:`EFF_CTRL_SA_LO];
    wire [2:0] x_bits  = ctrl_r[`EFF_CTRL_X_HI:`EFF_CTRL_X_LO];

    wire setup  = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire [3:0] sig_rd;

    // -------------------------------------------------------------
    // apb slave: read data captured in setup, zero wait access
    // -------------------------------------------------------------
    assign pready = 1'b1;
    assign irq    = |(status_r & mask_r);

    // read mux and unmapped detect, registered in setup phase
    always @(posedge core_clk) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en && setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            case (paddr)
                `EFF_OFF_CTRL:   prdata[`EFF_CTRL_W-1:0] <= ctrl_r;
                `EFF_OFF_STATUS: prdata[`EFF_ST_W-1:0] <= status_r;
                `EFF_OFF_MASK:   prdata[`EFF_ST_W-1:0] <= mask_r;
                `EFF_OFF_RXINFO: prdata[12:0] <= {rx_x_r, rx_sa_r, rx_e_r,
                                                  rx_yel_r, rx_alarm_r, 1'b0};
                `EFF_OFF_TXCTLB: prdata <= txctl_r;
                `EFF_OFF_RXCTLB: prdata <= rxctl_r;
                `EFF_OFF_DLINK:  prdata[15:0] <= {rxdl_r, txdl_r};
                `EFF_OFF_TXSIG:  prdata <= 32'h0000_0000;
                `EFF_OFF_RXSIG:  prdata[8:0] <= {rxsig_sel_r, sig_rd};
                default:         pslverr <= 1'b1;
            endcase
        end
    end

    // software writable registers; status is write-one-to-clear, set wins
    always @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_r      <= `EFF_CTRL_RST;
            mask_r      <= `EFF_MASK_RST;
            status_r    <= {`EFF_ST_W{1'b0}};
            txctl_r     <= 32'hFFFF_FFFF;
            txdl_r      <= 8'hFF;
            rxsig_sel_r <= 5'h00;
        end else if (clk_en) begin
            if (wr_acc && paddr == `EFF_OFF_CTRL)   ctrl_r <= pwdata[`EFF_CTRL_W-1:0];
            if (wr_acc && paddr == `EFF_OFF_MASK)   mask_r <= pwdata[`EFF_ST_W-1:0];
            if (wr_acc && paddr == `EFF_OFF_TXCTLB) txctl_r <= pwdata;
            if (wr_acc && paddr == `EFF_OFF_DLINK)  txdl_r <= pwdata[7:0];
            if (wr_acc && paddr == `EFF_OFF_RXSIG)  rxsig_sel_r <= pwdata[8:4];
            if (wr_acc && paddr == `EFF_OFF_STATUS)
                status_r <= (status_r & ~pwdata[`EFF_ST_W-1:0]) | ev;
            else
                status_r <= status_r | ev;
        end
    end

    // -------------------------------------------------------------
    // transmit position and overhead bit
    // -------------------------------------------------------------
    reg  [2:0] tx_bit_r;
    reg  [4:0] tx_slot_r;
    reg  [3:0] tx_frame_r;
    reg  [3:0] tx_crc_r, tx_crc_out_r;
    reg        e_pend_r;
    reg        tx_ovh, tx_ovh_bit;
    wire [3:0] sig_tx;
    wire [2:0] tk   = tx_frame_r[3:1];
    wire       tick = line_tx_tick & en;
    wire       tx_bit = tx_ovh ? tx_ovh_bit : tx_payload;
    wire [6:0] fas_w  = `EFF_FAS;
    wire [5:0] mfas_w = `EFF_MFAS;

    // table entry written by software: data[8:4] channel, data[3:0] ABCD
    eff_sig_mem #(.AW(5), .DW(4)) u_txsig (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr_en    (wr_acc && paddr == `EFF_OFF_TXSIG),
        .wr_addr  (pwdata[8:4]),
        .wr_data  (pwdata[3:0]),
        .rd_addr  ({tx_bit_r[2], tx_frame_r}),
        .rd_data  (sig_tx)
    );

    assign tx_payload_req = tick & ~tx_ovh;

    // overhead bit for the current position, bit index 0 is bit 1
    always @* begin
        tx_ovh     = 1'b0;
        tx_ovh_bit = 1'b0;
        if (tx_slot_r == 5'd0) begin
            tx_ovh = 1'b1;
            if (!tx_frame_r[0]) begin
                if (tx_bit_r == 3'd0)
                    tx_ovh_bit = crc_on ? tx_crc_out_r[3 - tx_frame_r[2:1]] : si_bit;
                else
                    tx_ovh_bit = fas_w[3'd7 - tx_bit_r];
            end else begin
                case (tx_bit_r)
                    3'd0: tx_ovh_bit = !crc_on ? si_bit :
                                       (tk >= 3'd6) ? ~e_pend_r :
                                       mfas_w[tk];
                    3'd1: tx_ovh_bit = 1'b1;
                    3'd2: tx_ovh_bit = ctrl_r[`EFF_CTRL_ALARM];
                    3'd3: tx_ovh_bit = irsm ? txdl_r[tk] : sa_bits[0];
                    default: tx_ovh_bit = irsm ?
                        txctl_r[{tx_bit_r[1], tk, tx_bit_r[0]}] :
                        sa_bits[tx_bit_r - 3'd3];
                endcase
            end
        end else if (tx_slot_r == `EFF_SLOT_SIG) begin
            tx_ovh = 1'b1;
            if (tx_frame_r == 4'd0) begin
                case (tx_bit_r)
                    3'd4:    tx_ovh_bit = x_bits[0];
                    3'd5:    tx_ovh_bit = ctrl_r[`EFF_CTRL_YEL];
                    3'd6:    tx_ovh_bit = x_bits[1];
                    3'd7:    tx_ovh_bit = x_bits[2];
                    default: tx_ovh_bit = 1'b0;
                endcase
            end else begin
                tx_ovh_bit = sig_tx[2'd3 - tx_bit_r[1:0]];
            end
        end
    end

    wire tx_sub_end = (tx_frame_r[2:0] == `EFF_SUB_LAST) &&
                      (tx_slot_r == `EFF_SLOT_LAST) && (tx_bit_r == `EFF_BIT_LAST);
    wire tx_cpos = (tx_slot_r == 5'd0) && !tx_frame_r[0] && (tx_bit_r == 3'd0);
    wire [3:0] tx_crc_nxt = crc_step(tx_crc_r, tx_cpos ? 1'b0 : tx_bit);
    wire rx_crc_err;

    // transmit counters, line bit and crc over each sub-multiframe
    always @(posedge core_clk) begin
        if (!reset_n) begin
            tx_bit_r     <= 3'd0;
            tx_slot_r    <= 5'd0;
            tx_frame_r   <= 4'd0;
            tx_crc_r     <= 4'h0;
            tx_crc_out_r <= 4'h0;
            line_tx_data <= 1'b1;
            e_pend_r     <= 1'b0;
        end else if (clk_en) begin
            if (tick) begin
                line_tx_data <= tx_bit;
                tx_bit_r     <= tx_bit_r + 3'd1;
                if (tx_bit_r == `EFF_BIT_LAST) begin
                    tx_slot_r <= tx_slot_r + 5'd1;
                    if (tx_slot_r == `EFF_SLOT_LAST)
                        tx_frame_r <= tx_frame_r + 4'd1;
                end
                if (tx_sub_end) begin
                    tx_crc_out_r <= tx_crc_nxt;
                    tx_crc_r     <= 4'h0;
                end else begin
                    tx_crc_r <= tx_crc_nxt;
                end
            end else if (!en) begin
                {tx_bit_r, tx_slot_r, tx_frame_r, tx_crc_r, tx_crc_out_r} <= 20'h00000;
            end
            // one pending error clears the next E bit sent; new error wins
            if (rx_crc_err)
                e_pend_r <= 1'b1;
            else if (tick && crc_on && tx_slot_r == 5'd0 && tx_bit_r == 3'd0 &&
                     tx_frame_r[0] && tk >= 3'd6)
                e_pend_r <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // receive side: pin synchronisers, position and checks
    // -------------------------------------------------------------
    reg  [1:0] rxd_sync_r, rxs_sync_r;
    reg  [2:0] rx_bit_r;
    reg  [4:0] rx_slot_r;
    reg  [3:0] rx_frame_r;
    reg  [6:0] rx_sh_r;
    reg  [3:0] rx_crc_r, rx_crc_prev_r, rx_c_r;
    reg        rx_crc_vld_r;
    wire       rtick  = line_rx_tick & en;
    wire       rbit   = rxd_sync_r[1];
    wire       rstart = rxs_sync_r[1];
    wire [2:0] rbi    = rstart ? 3'd0 : rx_bit_r;
    wire [4:0] rsl    = rstart ? 5'd0 : rx_slot_r;
    wire [3:0] rfr    = rstart ? 4'd0 : rx_frame_r;
    wire [2:0] rk     = rfr[3:1];
    wire [7:0] rbyte  = {rx_sh_r, rbit};
    wire       r_byte_end = rtick && rbi == `EFF_BIT_LAST;
    wire       r_cpos = (rsl == 5'd0) && !rfr[0] && (rbi == 3'd0);
    wire       r_sub_end = rtick && rfr[2:0] == `EFF_SUB_LAST &&
                           rsl == `EFF_SLOT_LAST && rbi == `EFF_BIT_LAST;
    wire [3:0] rx_crc_nxt = crc_step(rx_crc_r, r_cpos ? 1'b0 : rbit);
    wire       r_sig_wr = rtick && rsl == `EFF_SLOT_SIG && rfr != 4'd0 &&
                          rbi[1:0] == 2'd3;
    assign rx_crc_err = crc_on && r_sub_end && rx_crc_vld_r &&
                        (rx_c_r != rx_crc_prev_r);

    // received ABCD nibbles stored per channel, read by software
    eff_sig_mem #(.AW(5), .DW(4)) u_rxsig (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr_en    (r_sig_wr),
        .wr_addr  ({rbi[2], rfr}),
        .wr_data  ({rx_sh_r[2:0], rbit}),
        .rd_addr  (rxsig_sel_r),
        .rd_data  (sig_rd)
    );

    // event decode from completed overhead bytes and sub-multiframe ends
    always @* begin
        ev = {`EFF_ST_W{1'b0}};
        if (r_byte_end && rsl == 5'd0 && !rfr[0])
            ev[`EFF_ST_FAS] = (rbyte[6:0] != `EFF_FAS);
        if (r_byte_end && rsl == 5'd0 && rfr[0]) begin
            ev[`EFF_ST_NFAS] = ~rbyte[6];
            ev[`EFF_ST_RALM] = rbyte[5] & ~rx_alarm_r;
            ev[`EFF_ST_FEBE] = crc_on && rk >= 3'd6 && !rbyte[7];
            if (crc_on && rk < 3'd6 && rbyte[7] != mfas_w[rk])
                ev[`EFF_ST_NFAS] = 1'b1;
        end
        if (r_byte_end && rsl == `EFF_SLOT_SIG && rfr == 4'd0) begin
            ev[`EFF_ST_MAS] = (rbyte[7:4] != `EFF_MAS_ZERO);
            ev[`EFF_ST_YEL] = rbyte[2] & ~rx_yel_r;
        end
        ev[`EFF_ST_CRC] = rx_crc_err;
        ev[`EFF_ST_MF]  = r_sub_end && rfr == 4'd15;
    end

    // synchronisers, counters, capture of received overhead
    always @(posedge core_clk) begin
        if (!reset_n) begin
            rxd_sync_r     <= 2'b00;
            rxs_sync_r     <= 2'b00;
            rx_bit_r       <= 3'd0;
            rx_slot_r      <= 5'd0;
            rx_frame_r     <= 4'd0;
            rx_sh_r        <= 7'h00;
            rx_crc_r       <= 4'h0;
            rx_crc_prev_r  <= 4'h0;
            rx_c_r         <= 4'h0;
            rx_crc_vld_r   <= 1'b0;
            rx_alarm_r     <= 1'b0;
            rx_yel_r       <= 1'b0;
            rx_e_r         <= 2'b11;
            rx_sa_r        <= 5'h1F;
            rx_x_r         <= 3'h7;
            rxctl_r        <= 32'h0000_0000;
            rxdl_r         <= 8'h00;
            rx_payload     <= 1'b0;
            rx_payload_vld <= 1'b0;
        end else if (clk_en) begin
            rxd_sync_r     <= {rxd_sync_r[0], line_rx_data};
            rxs_sync_r     <= {rxs_sync_r[0], line_rx_sync};
            rx_payload_vld <= rtick && rsl != 5'd0 && rsl != `EFF_SLOT_SIG;
            if (rtick) begin
                rx_payload <= rbit;
                rx_sh_r    <= rbyte[6:0];
                rx_bit_r   <= rbi + 3'd1;
                rx_slot_r  <= (rbi == `EFF_BIT_LAST) ? rsl + 5'd1 : rsl;
                rx_frame_r <= (rbi == `EFF_BIT_LAST && rsl == `EFF_SLOT_LAST) ?
                              rfr + 4'd1 : rfr;
                if (r_cpos)
                    rx_c_r[3 - rfr[2:1]] <= rbit;
                if (r_sub_end) begin
                    rx_crc_prev_r <= rx_crc_nxt;
                    rx_crc_r      <= 4'h0;
                    rx_crc_vld_r  <= 1'b1;
                end else begin
                    rx_crc_r <= rstart ? 4'h0 : rx_crc_nxt;
                end
            end
            if (r_byte_end && rsl == 5'd0 && rfr[0]) begin
                rx_alarm_r <= rbyte[5];
                if (crc_on && rk >= 3'd6)
                    rx_e_r[rk[0]] <= rbyte[7];
                if (irsm) begin
                    rxdl_r[rk] <= rbyte[4];
                    rxctl_r[{1'b0, rk, 1'b0}] <= rbyte[3];
                    rxctl_r[{1'b0, rk, 1'b1}] <= rbyte[2];
                    rxctl_r[{1'b1, rk, 1'b0}] <= rbyte[1];
                    rxctl_r[{1'b1, rk, 1'b1}] <= rbyte[0];
                end else begin
                    rx_sa_r <= {rbyte[0], rbyte[1], rbyte[2], rbyte[3], rbyte[4]};
                end
            end
            if (r_byte_end && rsl == `EFF_SLOT_SIG && rfr == 4'd0) begin
                rx_yel_r <= rbyte[2];
                rx_x_r   <= {rbyte[0], rbyte[1], rbyte[3]};
            end
        end
    end
endmodule

// *** logic/eff_map.vh ***
// register offsets, field positions, reset values and framing patterns
`ifndef EFF_MAP_VH
`define EFF_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define EFF_OFF_CTRL     8'h00
`define EFF_OFF_STATUS   8'h04
`define EFF_OFF_MASK     8'h08
`define EFF_OFF_RXINFO   8'h0C
`define EFF_OFF_TXCTLB   8'h10
`define EFF_OFF_RXCTLB   8'h14
`define EFF_OFF_DLINK    8'h18
`define EFF_OFF_TXSIG    8'h1C
`define EFF_OFF_RXSIG    8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define EFF_CTRL_EN      0
`define EFF_CTRL_IRSM    1
`define EFF_CTRL_CRC     2
`define EFF_CTRL_ALARM   3
`define EFF_CTRL_YEL     4
`define EFF_CTRL_SA_LO   5
`define EFF_CTRL_SA_HI   9
`define EFF_CTRL_X_LO    10
`define EFF_CTRL_X_HI    12
`define EFF_CTRL_SI      13
`define EFF_CTRL_W       14
`define EFF_CTRL_RST     14'h3FE0

// ----------------------------------------------------------------
// status / mask bits
// ----------------------------------------------------------------
`define EFF_ST_FAS       0
`define EFF_ST_NFAS      1
`define EFF_ST_MAS       2
`define EFF_ST_CRC       3
`define EFF_ST_RALM      4
`define EFF_ST_YEL       5
`define EFF_ST_FEBE      6
`define EFF_ST_MF        7
`define EFF_ST_W         8
`define EFF_MASK_RST     8'h00

// ----------------------------------------------------------------
// framing patterns and frame geometry
// ----------------------------------------------------------------
`define EFF_FAS          7'h1B
`define EFF_MFAS         6'h34
`define EFF_MAS_ZERO     4'h0
`define EFF_CRC_POLY     4'h3
`define EFF_SLOT_SIG     5'd16
`define EFF_SLOT_LAST    5'd31
`define EFF_BIT_LAST     3'd7
`define EFF_SUB_LAST     3'd7

`endif

// *** logic/eff_sig_mem.v ***
// signalling nibble store, one write port and a registered read port
`timescale 1ns/1ps
module eff_sig_mem #(
    parameter AW = 5,
    parameter DW = 4
) (
    core_clk,   // system clock
    clk_en,     // freeze when low
    wr_en,      // write strobe
    wr_addr,    // write address
    wr_data,    // write data
    rd_addr,    // read address
    rd_data     // registered read data
);
    input  wire          core_clk;
    input  wire          clk_en;
    input  wire          wr_en;
    input  wire [AW-1:0] wr_addr;
    input  wire [DW-1:0] wr_data;
    input  wire [AW-1:0] rd_addr;
    output reg  [DW-1:0] rd_data;

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // -------------------------------------------------------------
    // storage and read register
    // -------------------------------------------------------------
    // no reset: contents come only from writes (software or receive stream), read data follows address
    always @(posedge core_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** test/eff_chk_asserts.sv ***
// port assertions for the e1 overhead framer
`timescale 1ns/1ps
module eff_chk (
    input wire       core_clk,       // clock
    input wire       reset_n,        // reset, low
    input wire [7:0] paddr,          // apb address
    input wire       psel,           // apb select
    input wire       penable,        // apb enable
    input wire       pwrite,         // apb write
    input wire       pslverr,        // apb error
    input wire       irq,            // interrupt
    input wire       line_tx_tick,   // tx strobe
    input wire       line_tx_data,   // tx bit
    input wire       tx_payload,     // payload in
    input wire       tx_payload_req, // payload taken
    input wire       line_rx_tick,   // rx strobe
    input wire       rx_payload_vld  // payload out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // payload only on a strobe, passed on the next cycle
    property p_req; tx_payload_req |-> line_tx_tick; endproperty
    a_req: assert property (p_req) else $error("request without strobe");
    property p_pass; tx_payload_req |=> line_tx_data == $past(tx_payload); endproperty
    a_pass: assert property (p_pass) else $error("payload bit lost");
    // line bit moves only after a strobe
    property p_hold; !$stable(line_tx_data) |-> $past(line_tx_tick); endproperty
    a_hold: assert property (p_hold) else $error("line bit moved off strobe");
    // receive payload follows a strobe, one cycle wide
    property p_vld; rx_payload_vld |-> $past(line_rx_tick); endproperty
    a_vld: assert property (p_vld) else $error("payload valid without strobe");
    property p_vld1; rx_payload_vld |=> !rx_payload_vld; endproperty
    a_vld1: assert property (p_vld1) else $error("payload valid too long");
    // unmapped or unaligned access is refused
    property p_err; psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");
    // interrupt edges need a write or a received byte
    property p_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
    a_fall: assert property (p_fall) else $error("interrupt dropped alone");
    property p_rise; $rose(irq) |-> $past(line_rx_tick || (psel && penable && pwrite));
    endproperty
    a_rise: assert property (p_rise) else $error("interrupt rose alone");
endmodule

// *** test/eff_host_framer_tb.sv ***
// self-checking bench for the e1 overhead framer
`timescale 1ns/1ps
module eff_host_framer_tb;
    reg          core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg          rx_on = 1'h0, alarm = 1'h0, yel = 1'h0, bad = 1'h0, tick_d = 1'h0, pay = 1'h0;
    reg          err;
    reg  [7:0]   paddr = 8'h00;
    reg  [31:0]  pwdata = 32'h0, rd;
    reg  [4095:0] txb;
    reg  [3:0]   crc;
    wire [31:0]  prdata;
    wire         pready, pslverr, irq, tx_tick, tx_data, tx_req, rx_tick, rx_data, rx_sync;
    integer      bad_count = 0, n_tests = 0, cyc = 0, idx = 0, i;
    eff_host_framer i_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'h1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .line_tx_tick(tx_tick), .line_tx_data(tx_data), .tx_payload(pay),
        .tx_payload_req(tx_req), .line_rx_tick(rx_tick), .line_rx_data(rx_data),
        .line_rx_sync(rx_sync), .rx_payload(), .rx_payload_vld());
    eff_remote i_far (.core_clk(core_clk), .rx_on(rx_on), .alarm(alarm), .yel(yel),
        .bad(bad), .tx_tick(tx_tick), .rx_tick(rx_tick), .rx_data(rx_data), .rx_sync(rx_sync));
    initial forever #25 core_clk = ~core_clk;
    // line monitor, toggling payload and hang guard
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        tick_d <= tx_tick;
        pay <= ~pay;
        if (tick_d && idx < 4096) begin
            txb[idx] = tx_data;
            idx = idx + 1;
        end
        if (cyc == 95000) begin
            bad_count = bad_count + 1;
            results;
        end
    end
    task results;
        begin
            if (bad_count == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task check(input [63:0] nm, input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'h1;
            @(posedge core_clk);
            while (!pready) @(posedge core_clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask
    task rchk(input [63:0] nm, input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            apb(1'h0, a, 32'h0);
            check(nm, rd & m, e);
        end
    endtask
    // restart framing on a strobe boundary and record one multiframe
    task cap(input [31:0] c);
        begin
            apb(1'h1, 8'h00, 32'h0);
            @(posedge core_clk);
            while (!tx_tick) @(posedge core_clk);
            apb(1'h1, 8'h00, c);
            idx = 0;
            wait (idx == 4096);
        end
    endtask
    function [7:0] sb(input integer f, input integer s);
        integer k;
        for (k = 0; k < 8; k = k + 1)
            sb[7 - k] = txb[f * 256 + s * 8 + k];
    endfunction
    task wait_irq(input integer n);
        for (i = 0; irq !== 1'h1 && i < n; i = i + 1)
            @(negedge core_clk);
    endtask
    task s_reset;
        begin
            rchk("ctrl", 8'h00, 32'hFFFFFFFF, 32'h3FE0);
            rchk("status", 8'h04, 32'hFFFFFFFF, 32'h0);
            rchk("mask", 8'h08, 32'hFFFFFFFF, 32'h0);
            rchk("txctlb", 8'h10, 32'hFFFFFFFF, 32'hFFFFFFFF);
            apb(1'h1, 8'h24, 32'h1);
            check("slverr", err, 32'h1);
        end
    endtask
    task s_itu;
        begin
            for (i = 0; i < 32; i = i + 1)
                apb(1'h1, 8'h1C, i * 16 + (i < 16 ? 10 : 5));
            cap(32'h36DD);
            for (i = 0; i < 16; i = i + 2) begin
                check("fas", sb(i, 0) & 8'h7F, 32'h1B);
                check("nfas", sb(i + 1, 0) & 8'h7F, 32'h6D);
                check("mfas", sb(i + 1, 0) >> 7, (8'hF4 >> (i / 2)) & 1);
            end
            crc = 4'h0;
            for (i = 0; i < 2048; i = i + 1)
                crc = {crc[2:0], 1'h0} ^ ((crc[3] ^ (txb[i] && i % 512 != 0)) ? 4'h3 : 4'h0);
            check("crc1", {txb[0], txb[512], txb[1024], txb[1536]}, 32'h0);
            check("crc2", {txb[2048], txb[2560], txb[3072], txb[3584]}, crc);
            check("mas", sb(0, 16), 32'h0D);
            check("sig", sb(1, 16), 32'hA5);
        end
    endtask
    task s_irsm;
        reg [39:0] t;
        begin
            t = 40'hC5_1234_ABCD;
            apb(1'h1, 8'h10, t[31:0]);
            apb(1'h1, 8'h18, t[39:32]);
            cap(32'h3);
            for (i = 0; i < 8; i = i + 1) begin
                check("fas", sb(2 * i, 0), 32'h1B);
                rd = {3'h2, t[32 + i], t[2 * i], t[2 * i + 1], t[2 * i + 16], t[2 * i + 17]};
                check("nfas", sb(2 * i + 1, 0), rd);
            end
        end
    endtask
    task s_rx;
        begin
            rx_on <= 1'h1;
            repeat (16500) @(posedge core_clk);
            rchk("rxstat", 8'h04, 32'h87, 32'h80);
            apb(1'h1, 8'h04, 32'hFF);
            apb(1'h1, 8'h08, 32'h30);
            alarm <= 1'h1;
            wait_irq(3000);
            check("irq", irq, 32'h1);
            rchk("rxinfo", 8'h0C, 32'h2, 32'h2);
            apb(1'h1, 8'h04, 32'h10);
            @(negedge core_clk);
            check("irqclr", irq, 32'h0);
            yel <= 1'h1;
            wait_irq(17000);
            rchk("rxinfo", 8'h0C, 32'h24, 32'h24);
            apb(1'h1, 8'h08, 32'h0);
            @(negedge core_clk);
            check("irqmask", irq, 32'h0);
            bad <= 1'h1;
            repeat (2100) @(posedge core_clk);
            rchk("faserr", 8'h04, 32'h1, 32'h1);
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'h1;
        s_reset;
        s_itu;
        s_irsm;
        s_rx;
        results;
    end
endmodule
bind eff_host_framer eff_chk i_chk (.*);

// *** test/eff_remote.sv ***
// remote e1 terminal: line strobes and a well formed receive stream
`timescale 1ns/1ps
module eff_remote (
    input  wire core_clk,        // clock
    input  wire rx_on,           // send receive stream
    input  wire alarm,           // remote alarm to send
    input  wire yel,             // multiframe yellow to send
    input  wire bad,             // corrupt alignment word
    output reg  tx_tick = 1'h0,  // transmit strobe
    output reg  rx_tick = 1'h0,  // receive strobe
    output reg  rx_data = 1'h1,  // receive bit
    output reg  rx_sync = 1'h0   // bit1 of frame 0
);
    reg  [1:0]  ph = 2'h0;
    reg  [11:0] pos = 12'h000;
    reg         run = 1'h0;
    reg  [7:0]  byt;
    wire [7:0]  mfa = 8'hF4;
    wire [3:0]  fr = pos[11:8];
    wire [4:0]  sl = pos[7:3];
    // slot byte, bit1 in the top place
    always @* begin
        byt = {fr, sl[3:0]};
        if (sl == 5'h00 && !fr[0])
            byt = {1'h1, 7'h1B ^ {6'h00, bad}};
        else if (sl == 5'h00)
            byt = {mfa[fr[3:1]], 1'h1, alarm, 5'h1F};
        else if (sl == 5'h10 && fr == 4'h0)
            byt = {4'h0, 1'h1, yel, 2'h3};
    end
    // four clocks a bit, data leads its strobe by three
    always @(posedge core_clk) begin
        ph <= ph + 2'h1;
        tx_tick <= ph == 2'h0;
        rx_tick <= run && ph == 2'h2;
        if (run && ph == 2'h2)
            pos <= pos + 12'h001;
        if (ph == 2'h3 && rx_on)
            run <= 1'h1;
        if (ph == 2'h3)
            rx_data <= rx_on ? byt[3'h7 - pos[2:0]] : ~rx_data;
        if (ph == 2'h3)
            rx_sync <= rx_on && pos == 12'h000;
    end
endmodule
